// File: scls_pkg.sv
// Constants, register map and types of the switch, config and status block.
// Assumes a 100 MHz clock and the plain strobe register port.
package scls_pkg;

  // ------------------------------------------------------------
  // Clock and indicator timing
  // ------------------------------------------------------------
  localparam int unsigned SCLS_CLK_HZ       = 100_000_000;
  localparam int unsigned SCLS_PHASE_MS     = 200;
  localparam int unsigned SCLS_PHASE_CYCLES =
    SCLS_PHASE_MS * (SCLS_CLK_HZ / 1000);
  localparam int unsigned SCLS_PHASE_W      = 25;
  localparam int unsigned SCLS_SEQ_W        = 3;
  localparam logic [2:0]  SCLS_SEQ_FIRST    = 3'h0;
  localparam logic [2:0]  SCLS_SEQ_SECOND   = 3'h2;

  // ------------------------------------------------------------
  // Switch decoding
  // ------------------------------------------------------------
  localparam int unsigned SCLS_CH          = 16;
  localparam logic [3:0]  SCLS_DIGIT_MAX   = 4'h9;
  localparam logic [7:0]  SCLS_NODE_MAX    = 8'h63;
  localparam logic [7:0]  SCLS_NODE_FWUPD  = 8'h00;
  localparam int unsigned SCLS_PAIR_BIT    = 3;
  localparam int unsigned SCLS_NODE_W      = 7;
  localparam logic [9:0]  SCLS_RATE_KBPS [8] = '{
    10'h00A, 10'h014, 10'h032, 10'h07D,
    10'h0FA, 10'h1F4, 10'h320, 10'h3E8
  };

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] SCLS_CONFIG_ADDR   = 8'h00;
  localparam logic [7:0] SCLS_NMT_ADDR      = 8'h04;
  localparam logic [7:0] SCLS_ERROR_ADDR    = 8'h08;
  localparam logic [7:0] SCLS_POLARITY_ADDR = 8'h0C;
  localparam logic [7:0] SCLS_INPUT_ADDR    = 8'h10;
  localparam logic [7:0] SCLS_PAIR_ADDR     = 8'h14;
  localparam logic [7:0] SCLS_TERM_ADDR     = 8'h18;
  localparam logic [7:0] SCLS_IRQ_STAT_ADDR = 8'h1C;
  localparam logic [7:0] SCLS_IRQ_CLR_ADDR  = 8'h20;
  localparam logic [7:0] SCLS_IRQ_EN_ADDR   = 8'h24;

  // Config word fields
  localparam int unsigned SCLS_CFG_RATE_LSB  = 8;
  localparam int unsigned SCLS_CFG_PAIR_BIT  = 12;
  localparam int unsigned SCLS_CFG_FWUPD_BIT = 13;
  localparam int unsigned SCLS_CFG_VALID_BIT = 14;
  localparam int unsigned SCLS_CFG_KBPS_LSB  = 16;

  // Interrupt events
  localparam int unsigned SCLS_IRQ_W       = 3;
  localparam int unsigned SCLS_IRQ_INPUT   = 0;
  localparam int unsigned SCLS_IRQ_NMT     = 1;
  localparam int unsigned SCLS_IRQ_ERROR   = 2;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    NMT_NONOP, NMT_STOPPED, NMT_PREOP, NMT_OPER
  } scls_nmt_t;

  typedef enum logic [1:0] {
    ERR_NONE, ERR_WARNING, ERR_GUARD, ERR_BUSOFF
  } scls_err_t;

  typedef enum logic [2:0] {
    PAT_OFF, PAT_ON, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE
  } scls_pat_t;

endpackage

// File: scls_led_if.sv
// Link between the indicator sequencer and one pattern generator.
// Assumes the phase tick is a one-cycle pulse in the shared clock domain.
`timescale 1ns/100ps
interface scls_led_if;
  import scls_pkg::*;
  logic      tick;
  scls_pat_t mode;
  logic      led;

  modport gen (
    input  tick,
    input  mode,
    output led
  );
  modport user (
    output tick,
    output mode,
    input  led
  );
endinterface

// File: scls_pattern.sv
// Indicator pattern generator: off, lit, blink, single and double flash.
// Assumes one tick per 200 ms phase; a group spans eight phases.
`timescale 1ns/100ps
module scls_pattern
  import scls_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  resetn,
  scls_led_if.gen    lif
);

  logic [SCLS_SEQ_W-1:0] phase_reg;
  logic                  led_reg;
  logic                  led_next;

  // ------------------------------------------------------------
  // Phase counter
  // ------------------------------------------------------------
  // Wraps by itself, so all indicators stay in step.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= '0;
    end else if (lif.tick) begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Pattern
  // ------------------------------------------------------------
  // Flashes are one phase on; a single then pauses seven phases, a double one phase between flashes and five after.
  always_comb begin
    case (lif.mode)
      PAT_ON:     led_next = 1'b1;
      PAT_BLINK:  led_next = ~phase_reg[0];
      PAT_SINGLE: led_next = (phase_reg == SCLS_SEQ_FIRST);
      PAT_DOUBLE: led_next = (phase_reg == SCLS_SEQ_FIRST) ||
                             (phase_reg == SCLS_SEQ_SECOND);
      default:    led_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      led_reg <= 1'b0;
    end else begin
      led_reg <= led_next;
    end
  end

  assign lif.led = led_reg;

endmodule

// File: scls_top.sv
// Switch decoding, pairing mode, indicator and status logic of a
// 16-channel input slave. Assumes switch and input pins are synchronous
// to clk and that the protocol firmware drives the register port.
//
// What this block does
// - Node identifier is tens switch times ten plus units switch.
// - Identifiers one through 99 are valid for normal slave operation.
// - Identifier zero selects firmware update mode, not slave operation.
// - Rate switch 0 to 7 is normal, 8 to F is pairing.
// - Low three rate bits pick 10 to 1000 kbps, same in both modes.
// - Pairing mode enters Operational by itself, no start command needed.
// - In pairing, each active input switches on the partner's same output.
// - Run light: dark, single flash, blink, lit by state.
// - Error light: dark, single flash, double flash, lit by error state.
// - Termination light is lit while the terminator is enabled.
// - Channel lights show raw input level, ignoring polarity inversion.
// - Per-channel input polarity can be inverted by software.
`timescale 1ns/100ps
module scls_top
  import scls_pkg::*;
#(
  parameter int unsigned PHASE_CYCLES = SCLS_PHASE_CYCLES
)
(
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [3:0]             node_tens_sw,
  input  wire logic [3:0]             node_units_sw,
  input  wire logic [3:0]             rate_sw,
  input  wire logic [SCLS_CH-1:0]     input_channel,
  input  wire logic [7:0]             addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic      [31:0]            rdata,
  output logic [SCLS_NODE_W-1:0]      node_id,
  output logic      [2:0]             rate_code,
  output logic      [9:0]             rate_kbps,
  output logic                        pair_mode,
  output logic                        fw_update,
  output logic                        node_valid,
  output logic [SCLS_CH-1:0]          input_value,
  output logic [SCLS_CH-1:0]          pair_out,
  output logic                        term_enable,
  output logic                        supply_indicator,
  output logic                        run_led,
  output logic                        err_led,
  output logic                        term_led,
  output logic [SCLS_CH-1:0]          input_channel_led,
  output logic                        irq
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic                   sampled_reg;
  logic [SCLS_NODE_W-1:0] node_reg;
  logic [2:0]             rate_reg;
  logic                   pair_reg;
  logic                   fwupd_reg;
  logic                   valid_reg;
  logic [7:0]             node_sum;
  logic                   digits_ok;
  scls_nmt_t              nmt_reg;
  scls_nmt_t              nmt_next;
  scls_err_t              err_reg;
  logic [SCLS_CH-1:0]     polarity_reg;
  logic [SCLS_CH-1:0]     raw_reg;
  logic [SCLS_CH-1:0]     value_reg;
  logic [SCLS_CH-1:0]     pair_out_reg;
  logic                   term_reg;
  logic [SCLS_IRQ_W-1:0]  irq_stat_reg;
  logic [SCLS_IRQ_W-1:0]  irq_en_reg;
  logic [SCLS_IRQ_W-1:0]  irq_event;
  logic [SCLS_IRQ_W-1:0]  irq_clear;
  logic [31:0]            rdata_reg;
  logic [31:0]            rd_word;
  logic [31:0]            cfg_word;
  logic [SCLS_PHASE_W-1:0] phase_cnt_reg;
  logic                   phase_tick;
  logic                   nmt_changed;
  logic                   err_changed;

  scls_led_if run_if ();
  scls_led_if err_if ();

  // ------------------------------------------------------------
  // Switch decoding
  // ------------------------------------------------------------
  // Tens digit times ten is built from two shifts.
  assign node_sum  = ({4'h0, node_tens_sw} << 3) +
                     ({4'h0, node_tens_sw} << 1) +
                     {4'h0, node_units_sw};
  assign digits_ok = (node_tens_sw <= SCLS_DIGIT_MAX) &&
                     (node_units_sw <= SCLS_DIGIT_MAX);

  // Captured once; turning a switch later has no effect until reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sampled_reg <= 1'b0;
      node_reg    <= '0;
      rate_reg    <= '0;
      pair_reg    <= 1'b0;
      fwupd_reg   <= 1'b0;
      valid_reg   <= 1'b0;
    end else if (!sampled_reg) begin
      sampled_reg <= 1'b1;
      node_reg    <= node_sum[SCLS_NODE_W-1:0];
      rate_reg    <= rate_sw[2:0];
      pair_reg    <= rate_sw[SCLS_PAIR_BIT];
      fwupd_reg   <= digits_ok && (node_sum == SCLS_NODE_FWUPD);
      valid_reg   <= digits_ok && (node_sum != SCLS_NODE_FWUPD) &&
                     (node_sum <= SCLS_NODE_MAX);
    end
  end

  assign node_id    = node_reg;
  assign rate_code  = rate_reg;
  assign rate_kbps  = SCLS_RATE_KBPS[rate_reg];
  assign pair_mode  = pair_reg;
  assign fw_update  = fwupd_reg;
  assign node_valid = valid_reg;

  // ------------------------------------------------------------
  // Network state
  // ------------------------------------------------------------
  // Pairing jumps straight to Operational once the switches are in;
  // a pair has no master to send the start command.
  always_comb begin
    nmt_next = nmt_reg;
    if (!sampled_reg) begin
      nmt_next = NMT_NONOP;
    end else if (nmt_reg == NMT_NONOP && pair_reg && valid_reg) begin
      nmt_next = NMT_OPER;
    end else if (wr_stb && addr == SCLS_NMT_ADDR && valid_reg) begin
      nmt_next = scls_nmt_t'(wdata[1:0]);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nmt_reg <= NMT_NONOP;
    end else begin
      nmt_reg <= nmt_next;
    end
  end

  assign nmt_changed = (nmt_next != nmt_reg);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_reg <= ERR_NONE;
    end else if (wr_stb && addr == SCLS_ERROR_ADDR) begin
      err_reg <= scls_err_t'(wdata[1:0]);
    end
  end

  assign err_changed = wr_stb && (addr == SCLS_ERROR_ADDR) &&
                       (scls_err_t'(wdata[1:0]) != err_reg);

  // ------------------------------------------------------------
  // Inputs, polarity and pairing outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      polarity_reg <= '0;
      term_reg     <= 1'b0;
    end else if (wr_stb) begin
      if (addr == SCLS_POLARITY_ADDR) begin
        polarity_reg <= wdata[SCLS_CH-1:0];
      end else if (addr == SCLS_TERM_ADDR) begin
        term_reg <= wdata[0];
      end
    end
  end

  // The partner follows the raw ON level, not the inverted value.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      raw_reg      <= '0;
      value_reg    <= '0;
      pair_out_reg <= '0;
    end else begin
      raw_reg      <= input_channel;
      value_reg    <= input_channel ^ polarity_reg;
      pair_out_reg <= (pair_reg && nmt_reg == NMT_OPER) ?
                      input_channel : '0;
    end
  end

  assign input_value       = value_reg;
  assign pair_out          = pair_out_reg;
  assign input_channel_led = raw_reg;
  assign term_enable       = term_reg;
  assign term_led          = term_reg;
  assign supply_indicator  = 1'b1;

  // ------------------------------------------------------------
  // Indicators
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_cnt_reg <= '0;
    end else if (phase_tick) begin
      phase_cnt_reg <= '0;
    end else begin
      phase_cnt_reg <= phase_cnt_reg + 1'b1;
    end
  end

  assign phase_tick = (phase_cnt_reg ==
                       SCLS_PHASE_W'(PHASE_CYCLES - 1));
  assign run_if.tick = phase_tick;
  assign err_if.tick = phase_tick;

  always_comb begin
    case (nmt_reg)
      NMT_STOPPED: run_if.mode = PAT_SINGLE;
      NMT_PREOP:   run_if.mode = PAT_BLINK;
      NMT_OPER:    run_if.mode = PAT_ON;
      default:     run_if.mode = PAT_OFF;
    endcase
  end

  always_comb begin
    case (err_reg)
      ERR_WARNING: err_if.mode = PAT_SINGLE;
      ERR_GUARD:   err_if.mode = PAT_DOUBLE;
      ERR_BUSOFF:  err_if.mode = PAT_ON;
      default:     err_if.mode = PAT_OFF;
    endcase
  end

  scls_pattern run_gen (
    .clk    (clk),
    .resetn (resetn),
    .lif    (run_if)
  );

  scls_pattern err_gen (
    .clk    (clk),
    .resetn (resetn),
    .lif    (err_if)
  );

  assign run_led = run_if.led;
  assign err_led = err_if.led;

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  assign irq_event[SCLS_IRQ_INPUT] = (input_channel != raw_reg);
  assign irq_event[SCLS_IRQ_NMT]   = nmt_changed;
  assign irq_event[SCLS_IRQ_ERROR] = err_changed;
  assign irq_clear = (wr_stb && addr == SCLS_IRQ_CLR_ADDR) ?
                     wdata[SCLS_IRQ_W-1:0] : '0;

  // A new event beats a clear in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_reg <= '0;
    end else if (wr_stb && addr == SCLS_IRQ_EN_ADDR) begin
      irq_en_reg <= wdata[SCLS_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  always_comb begin
    cfg_word = '0;
    cfg_word[SCLS_NODE_W-1:0] = node_reg;
    cfg_word[SCLS_CFG_RATE_LSB +: 3] = rate_reg;
    cfg_word[SCLS_CFG_PAIR_BIT]  = pair_reg;
    cfg_word[SCLS_CFG_FWUPD_BIT] = fwupd_reg;
    cfg_word[SCLS_CFG_VALID_BIT] = valid_reg;
    cfg_word[SCLS_CFG_KBPS_LSB +: 10] = SCLS_RATE_KBPS[rate_reg];
  end

  // Write-only and unmapped addresses read as zero.
  always_comb begin
    rd_word = '0;
    if (addr == SCLS_CONFIG_ADDR) begin
      rd_word = cfg_word;
    end else if (addr == SCLS_NMT_ADDR) begin
      rd_word = {30'h0, nmt_reg};
    end else if (addr == SCLS_ERROR_ADDR) begin
      rd_word = {30'h0, err_reg};
    end else if (addr == SCLS_POLARITY_ADDR) begin
      rd_word = {16'h0, polarity_reg};
    end else if (addr == SCLS_INPUT_ADDR) begin
      rd_word = {raw_reg, value_reg};
    end else if (addr == SCLS_PAIR_ADDR) begin
      rd_word = {16'h0, pair_out_reg};
    end else if (addr == SCLS_TERM_ADDR) begin
      rd_word = {31'h0, term_reg};
    end else if (addr == SCLS_IRQ_STAT_ADDR) begin
      rd_word = {29'h0, irq_stat_reg};
    end else if (addr == SCLS_IRQ_EN_ADDR) begin
      rd_word = {29'h0, irq_en_reg};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= '0;
    end else if (rd_stb) begin
      rdata_reg <= rd_word;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata = rdata_reg;

endmodule

// File: scls_chk.sv
// Concurrent checks on the ports of the switch, config and status block.
// Assumes binding into scls_top; sees nothing but its ports.
`timescale 1ns/100ps
module scls_chk
  import scls_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic [3:0]             node_tens_sw,
  input wire logic [3:0]             node_units_sw,
  input wire logic [3:0]             rate_sw,
  input wire logic [SCLS_CH-1:0]     input_channel,
  input wire logic [SCLS_NODE_W-1:0] node_id,
  input wire logic [2:0]             rate_code,
  input wire logic [9:0]             rate_kbps,
  input wire logic                   pair_mode,
  input wire logic                   fw_update,
  input wire logic                   node_valid,
  input wire logic [SCLS_CH-1:0]     pair_out,
  input wire logic                   term_enable,
  input wire logic                   run_led,
  input wire logic                   term_led,
  input wire logic [SCLS_CH-1:0]     input_channel_led
);
  // ----------------------------------------------------------
  // Switch capture mirror
  // ----------------------------------------------------------
  logic       cap_done;
  logic [3:0] cap_t;
  logic [3:0] cap_u;
  logic [3:0] cap_r;
  logic       dig_ok;

  // Mirrors the single capture at the first edge after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cap_done <= 1'b0;
      cap_t    <= 4'h0;
      cap_u    <= 4'h0;
      cap_r    <= 4'h0;
    end else if (!cap_done) begin
      cap_done <= 1'b1;
      cap_t    <= node_tens_sw;
      cap_u    <= node_units_sw;
      cap_r    <= rate_sw;
    end
  end
  assign dig_ok = (cap_t <= 4'h9) && (cap_u <= 4'h9);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  sequence s_auto;
    $rose(cap_done) ##0 (pair_mode && node_valid);
  endsequence

  property p_decode;
    cap_done && dig_ok |-> node_id == SCLS_NODE_W'(cap_t * 10 + cap_u);
  endproperty
  property p_valid;
    cap_done |-> node_valid == (dig_ok && (cap_t != 4'h0 || cap_u != 4'h0));
  endproperty
  property p_fwupd;
    cap_done |-> fw_update == (dig_ok && cap_t == 4'h0 && cap_u == 4'h0);
  endproperty
  property p_mode;
    cap_done |-> pair_mode == cap_r[3] && rate_code == cap_r[2:0];
  endproperty
  property p_kbps;
    cap_done |-> rate_kbps == SCLS_RATE_KBPS[rate_code];
  endproperty
  property p_auto;
    s_auto |-> ##2 run_led [*4];
  endproperty
  property p_pair;
    pair_out == '0 || (pair_mode && pair_out == $past(input_channel));
  endproperty
  property p_chled;
    cap_done |-> input_channel_led == $past(input_channel);
  endproperty
  // Light and enable come from one flop, so they change in the same cycle
  property p_term;
    cap_done |-> term_led == term_enable;
  endproperty

  a_decode: assert property (p_decode)
    else $error("node id decode wrong");
  a_valid: assert property (p_valid)
    else $error("node valid flag wrong");
  a_fwupd: assert property (p_fwupd)
    else $error("firmware update flag wrong");
  a_mode: assert property (p_mode)
    else $error("mode or rate code wrong");
  a_kbps: assert property (p_kbps)
    else $error("bit rate wrong");
  a_auto: assert property (p_auto)
    else $error("pairing did not go operational");
  a_pair: assert property (p_pair)
    else $error("pair output wrong");
  a_chled: assert property (p_chled)
    else $error("channel light wrong");
  a_term: assert property (p_term)
    else $error("termination light wrong");
endmodule

bind scls_top scls_chk u_chk (
  .clk, .resetn, .node_tens_sw, .node_units_sw, .rate_sw, .input_channel,
  .node_id, .rate_code, .rate_kbps, .pair_mode, .fw_update, .node_valid,
  .pair_out, .term_enable, .run_led, .term_led, .input_channel_led
);

// File: scls_peer.sv
// Model of the paired output module across the link.
// Assumes the demanded channel set arrives in the shared clock domain.
`timescale 1ns/100ps
module scls_peer
  import scls_pkg::*;
#(
  parameter int unsigned OWN_ID = 1
)
(
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [SCLS_NODE_W-1:0] partner_id,
  input  wire logic [SCLS_CH-1:0]     demand,
  output logic      [SCLS_CH-1:0]     out_on
);
  logic paired;

  // A pair needs an odd own id and the partner one above it
  assign paired = OWN_ID[0] &&
                  (partner_id == SCLS_NODE_W'(OWN_ID + 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_on <= '0;
    end else begin
      out_on <= paired ? demand : '0;
    end
  end
endmodule

// File: tb.sv
// Self-checking bench of the switch, config and status block.
// Assumes the design, its bound checker and the peer model compile first.
`timescale 1ns/100ps
module tb;
  import scls_pkg::*;
  localparam int unsigned PH = 4;
  localparam logic [9:0] KB [8] = '{10'h00A, 10'h014, 10'h032, 10'h07D,
                                    10'h0FA, 10'h1F4, 10'h320, 10'h3E8};
  localparam int RUNX [4] = '{0, PH, 4 * PH, 8 * PH};
  localparam int ERRX [4] = '{0, PH, 2 * PH, 8 * PH};
  localparam logic [3:0] FT [3] = '{4'h0, 4'h9, 4'hA};
  localparam logic [3:0] FU [3] = '{4'h0, 4'h9, 4'h3};
  localparam logic [3:0] FR [3] = '{4'h0, 4'h7, 4'h8};

  logic clk = 1'b0, resetn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [3:0] node_tens_sw = 4'h0, node_units_sw = 4'h0, rate_sw = 4'h0;
  logic [SCLS_CH-1:0] input_channel = '0, input_value, pair_out, peer_on;
  logic [SCLS_CH-1:0] input_channel_led, x, p;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, e, seed = 32'h1;
  logic [SCLS_NODE_W-1:0] node_id;
  logic [2:0] rate_code;
  logic [9:0] rate_kbps;
  logic [3:0] t, u, r;
  logic pair_mode, fw_update, node_valid, term_enable, supply_indicator;
  logic run_led, err_led, term_led, irq;
  int error_cnt = 0, checked = 0, nr, ne;

  scls_top #(.PHASE_CYCLES(PH)) dut (.clk, .resetn, .node_tens_sw,
    .node_units_sw, .rate_sw, .input_channel, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .node_id, .rate_code, .rate_kbps, .pair_mode, .fw_update,
    .node_valid, .input_value, .pair_out, .term_enable, .supply_indicator,
    .run_led, .err_led, .term_led, .input_channel_led, .irq);
  scls_peer #(.OWN_ID(1)) u_peer (.clk, .resetn, .partner_id(node_id),
    .demand(pair_out), .out_on(peer_on));

  always #5 clk = ~clk;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_cfg(input logic [3:0] a, b, c);
    logic       ok;
    logic [6:0] id;
    ok = (a <= 4'h9) && (b <= 4'h9);
    id = 7'(a * 10 + b);
    exp_cfg = {6'h0, KB[c[2:0]], 1'b0, ok && id != 7'h00,
               ok && id == 7'h00, c[3], 1'b0, c[2:0], 1'b0, id};
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, got);
    checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Switches are only taken at the first edge after reset
  task automatic boot(input logic [3:0] a, b, c);
    @(posedge clk);
    resetn        <= 1'b0;
    node_tens_sw  <= a;
    node_units_sw <= b;
    rate_sw       <= c;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    cycles(3);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  initial begin
    for (int i = 0; i < 19; i++) begin
      t = (i < 3) ? FT[i] : 4'(rnd() % 11);
      u = (i < 3) ? FU[i] : 4'(rnd() % 10);
      r = (i < 3) ? FR[i] : 4'(i - 3);
      boot(t, u, r);
      e = exp_cfg(t, u, r);
      rd(SCLS_CONFIG_ADDR, d);
      chk("config", e, d);
      chk("kbps", 32'(e[25:16]), 32'(rate_kbps));
      rd(SCLS_NMT_ADDR, d);
      chk("nmt", (e[12] && e[14]) ? 32'h3 : 32'h0, d);
      @(posedge clk);
      node_tens_sw <= ~t;
      rate_sw      <= ~r;
      cycles(2);
      chk("held", e, {6'h0, rate_kbps, 1'b0, node_valid, fw_update, pair_mode,
          1'b0, rate_code, 1'b0, node_id});
    end
    chk("supply", 32'h1, 32'(supply_indicator));
    $display("test switches done");
    boot(4'h0, 4'h2, 4'hD);
    repeat (8) begin
      @(posedge clk);
      x = 16'(rnd());
      input_channel <= x;
      cycles(2);
      chk("pair_out", 32'(x), 32'(pair_out));
      chk("peer_on", 32'(x), 32'(peer_on));
    end
    $display("test pairing done");
    boot(4'h0, 4'h2, 4'h5);
    wr(SCLS_NMT_ADDR, 32'h3);
    repeat (6) begin
      p = 16'(rnd());
      x = 16'(rnd());
      wr(SCLS_POLARITY_ADDR, 32'(p));
      @(posedge clk);
      input_channel <= x;
      cycles(2);
      chk("input_value", 32'(x ^ p), 32'(input_value));
      chk("channel led", 32'(x), 32'(input_channel_led));
      chk("no pair", 32'h0, 32'(pair_out));
      rd(SCLS_INPUT_ADDR, d);
      chk("input reg", {x, x ^ p}, d);
    end
    for (int k = 1; k >= 0; k--) begin
      wr(SCLS_TERM_ADDR, 32'(k));
      cycles(1);
      chk("term_led", 32'(k), 32'(term_led));
    end
    $display("test polarity and lights done");
    for (int s = 0; s < 4; s++) begin
      wr(SCLS_NMT_ADDR, 32'(s));
      wr(SCLS_ERROR_ADDR, 32'(s));
      cycles(2);
      nr = 0;
      ne = 0;
      // A whole group of eight phases makes the count phase-independent
      repeat (8 * PH) begin
        @(posedge clk);
        #1;
        nr += int'(run_led);
        ne += int'(err_led);
      end
      chk("run lit", RUNX[s], nr);
      chk("err lit", ERRX[s], ne);
    end
    $display("test patterns done");
    wr(SCLS_IRQ_EN_ADDR, 32'h1);
    wr(SCLS_IRQ_CLR_ADDR, 32'h7);
    chk("irq idle", 32'h0, 32'(irq));
    @(posedge clk);
    input_channel <= ~input_channel;
    cycles(2);
    chk("irq set", 32'h1, 32'(irq));
    wr(SCLS_IRQ_EN_ADDR, 32'h0);
    chk("irq masked", 32'h0, 32'(irq));
    rd(SCLS_IRQ_STAT_ADDR, d);
    chk("irq stat", 32'h1, d);
    // Read data stands for one cycle only, then drops to zero
    cycles(1);
    chk("rdata idle", 32'h0, rdata);
    wr(SCLS_IRQ_CLR_ADDR, 32'h1);
    wr(SCLS_IRQ_EN_ADDR, 32'h7);
    chk("irq cleared", 32'h0, 32'(irq));
    rd(8'hFC, d);
    chk("unmapped", 32'h0, d);
    rd(SCLS_IRQ_CLR_ADDR, d);
    chk("write only", 32'h0, d);
    wr(SCLS_CONFIG_ADDR, 32'hFFFF_FFFF);
    rd(SCLS_CONFIG_ADDR, d);
    chk("config ro", exp_cfg(4'h0, 4'h2, 4'h5), d);
    $display("test interrupts done");
    close_out();
  end
endmodule
